// >>> rtl/fsps_params.svh
`ifndef FSPS_PARAMS_SVH
`define FSPS_PARAMS_SVH

// control register bit positions
`define FSPS_CTL_STORE_EN 0
`define FSPS_CTL_PGERS 1
`define FSPS_CTL_PGWRT 2
`define FSPS_CTL_LOCKSET 3
`define FSPS_CTL_RWWRE 4
`define FSPS_CTL_SIG_READ 5
`define FSPS_CTL_BUSY 6
`define FSPS_CTL_IE 7

// command patterns (bits 7:6 masked off before compare)
`define FSPS_CMD_MASK 8'h3f
`define FSPS_CMD_LOAD 8'h01
`define FSPS_CMD_WRITE 8'h05
`define FSPS_CMD_LOCKSET 8'h09
`define FSPS_CMD_REEN 8'h11
`define FSPS_CMD_SIG_READ 8'h21

// register offsets
`define FSPS_REG_CTL 4'h0
`define FSPS_REG_ZLO 4'h1
`define FSPS_REG_ZHI 4'h2
`define FSPS_REG_ZEXT 4'h3
`define FSPS_REG_OPLO 4'h4
`define FSPS_REG_OPHI 4'h5
`define FSPS_REG_STAT 4'h6
`define FSPS_REG_LOCK 4'h7

// windows in cycles after the control write
`define FSPS_STORE_WIN 3'd4
`define FSPS_LOAD_WIN 3'd3

// page geometry: 128 words, page index z[16:8]
`define FSPS_PAGE_WORDS 128
`define FSPS_NOREAD_PAGE 9'd480

// programming times
`define FSPS_WRITE_US 4500
`define FSPS_CLK_MHZ 250
`define FSPS_WRITE_CYC (`FSPS_WRITE_US * `FSPS_CLK_MHZ)

// reset values
`define FSPS_LOCK_RST 8'hff
`define FSPS_FUSE_LO 8'h62
`define FSPS_FUSE_HI 8'h99
`define FSPS_FUSE_EXT 8'hff
// signature bytes: arbitrary values
`define FSPS_SIG0 8'h5a
`define FSPS_SIG1 8'h3c
`define FSPS_SIG2 8'h01
`define FSPS_OSCCAL 8'h80

`endif

// >>> rtl/fsps_pkg.sv
package fsps_pkg;
  typedef enum logic [2:0] {
    FSPS_IDLE,
    FSPS_ARMED,
    FSPS_WRITING,
    FSPS_LOCKING,
    FSPS_DONE_WAIT
  } fsps_state_t;
endpackage

// >>> rtl/fsps_sequencer.sv
`timescale 1ns/1ns
`include "fsps_params.svh"
// Summary of operation
// - control 01 then store loads one buffer word
// - page word index selects buffer location
// - buffer cleared after write, reenable, reset
// - eeprom write keeps loaded buffer words
// - control x5 then store starts page write
// - no-read-while-write page write halts the cpu
// - interrupt level while store enable clear
// - read-while-write reads blocked during page write
// - busy flag set while section blocked
// - reenable clears busy flag, unblocks section
// - control x9 then store sets lock bits
// - zero operand bits 5:0 program locks
// - flash stays readable during lock programming
// - eeprom activity refuses programming and reads
// - lock read with index 0x0001 within three
// - command bits clear on completion or timeout
// - fuse bytes at indices zero, three, two
// - programmed bits read zero, others one
// - signature read within three cycles
// - signature bytes at 0,2,4, calibration 1
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int WRITE_CYC = `FSPS_WRITE_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic store_instr,
  input wire logic load_instr,
  input wire logic eeprom_write_active_bit,
  output logic [7:0] load_data,
  output logic load_data_valid,
  output logic cpu_halt,
  output logic rww_read_block,
  output logic store_irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fsps_state_t st;
    logic [7:0] ctl;
    logic [16:0] z;
    logic [15:0] op;
    logic [2:0] win;
    logic [8:0] page;
    logic [22:0] cnt;
    logic [7:0] lock;
    logic [`FSPS_PAGE_WORDS*16-1:0] buf_data;
    logic [`FSPS_PAGE_WORDS-1:0] buf_full;
    logic [7:0] rdata;
    logic [7:0] ld_data;
    logic ld_valid;
    logic halt;
    logic block;
    logic irq;
  } fsps_state_s_t;

  fsps_state_s_t s_q;
  fsps_state_s_t s_d;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] fsps_cmd(input logic [7:0] c);
    fsps_cmd = c & `FSPS_CMD_MASK;
  endfunction

  // signature row bytes; unlisted indices read as erased
  function automatic logic [7:0] fsps_sig_byte(input logic [15:0] idx);
    case (idx)
      16'h0000: begin
        fsps_sig_byte = `FSPS_SIG0;
      end
      16'h0001: begin
        fsps_sig_byte = `FSPS_OSCCAL;
      end
      16'h0002: begin
        fsps_sig_byte = `FSPS_SIG1;
      end
      16'h0004: begin
        fsps_sig_byte = `FSPS_SIG2;
      end
      default: begin
        fsps_sig_byte = 8'hff;
      end
    endcase
  endfunction

  // programmed bits read zero, unprogrammed bits read one
  function automatic logic [7:0] fsps_fuse_byte(input logic [15:0] idx,
      input logic [7:0] lock);
    case (idx)
      16'h0000: begin
        fsps_fuse_byte = `FSPS_FUSE_LO;
      end
      16'h0001: begin
        fsps_fuse_byte = lock;
      end
      16'h0002: begin
        // only three extended bits exist, the rest read zero
        fsps_fuse_byte = {5'h00, 3'(`FSPS_FUSE_EXT)};
      end
      16'h0003: begin
        fsps_fuse_byte = `FSPS_FUSE_HI;
      end
      default: begin
        fsps_fuse_byte = 8'hff;
      end
    endcase
  endfunction

  // true while a store may still be taken for the armed command
  function automatic logic fsps_store_open(input logic [2:0] w);
    fsps_store_open = (w < `FSPS_STORE_WIN);
  endfunction

  function automatic logic fsps_load_open(input logic [2:0] w);
    fsps_load_open = (w < `FSPS_LOAD_WIN);
  endfunction

  logic [7:0] cmd;
  logic [6:0] widx;
  logic [15:0] zlow;
  logic store_ok;
  logic load_ok;
  logic win_last;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.ld_valid = 1'b0;
    cmd = fsps_cmd(s_q.ctl);
    widx = s_q.z[7:1];
    zlow = s_q.z[15:0];
    // an eeprom write started after arming still refuses the command
    store_ok = store_instr && !eeprom_write_active_bit &&
               fsps_store_open(s_q.win);
    load_ok = load_instr && !eeprom_write_active_bit &&
              fsps_load_open(s_q.win);
    // the signature read has no store form, so its window is shorter
    if (cmd == `FSPS_CMD_SIG_READ) begin
      win_last = (s_q.win >= `FSPS_LOAD_WIN - 3'd1);
    end else begin
      win_last = (s_q.win >= `FSPS_STORE_WIN - 3'd1);
    end

    // ****************************************
    // register writes
    // ****************************************
    if (reg_wr) begin
      case (reg_addr)
        `FSPS_REG_CTL: begin
          // writes refused while a command is armed or running or eeprom active; IE is still taken while not idle
          if (s_q.st == FSPS_IDLE && !eeprom_write_active_bit) begin
            s_d.ctl[`FSPS_CTL_IE] = reg_wdata[`FSPS_CTL_IE];
            s_d.ctl[5:0] = reg_wdata[5:0];
            if (reg_wdata[`FSPS_CTL_STORE_EN]) begin
              s_d.st = FSPS_ARMED;
              s_d.win = 3'd0;
            end
          end else if (s_q.st != FSPS_IDLE) begin
            s_d.ctl[`FSPS_CTL_IE] = reg_wdata[`FSPS_CTL_IE];
          end
        end
        `FSPS_REG_ZLO: begin
          s_d.z[7:0] = reg_wdata;
        end
        `FSPS_REG_ZHI: begin
          s_d.z[15:8] = reg_wdata;
        end
        `FSPS_REG_ZEXT: begin
          s_d.z[16] = reg_wdata[0];
        end
        `FSPS_REG_OPLO: begin
          s_d.op[7:0] = reg_wdata;
        end
        `FSPS_REG_OPHI: begin
          s_d.op[15:8] = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // register reads, data in the next cycle
    // ****************************************
    if (reg_rd) begin
      case (reg_addr)
        `FSPS_REG_CTL: begin
          s_d.rdata = s_q.ctl;
        end
        `FSPS_REG_ZLO: begin
          s_d.rdata = s_q.z[7:0];
        end
        `FSPS_REG_ZHI: begin
          s_d.rdata = s_q.z[15:8];
        end
        `FSPS_REG_ZEXT: begin
          s_d.rdata = {7'h00, s_q.z[16]};
        end
        `FSPS_REG_OPLO: begin
          s_d.rdata = s_q.op[7:0];
        end
        `FSPS_REG_OPHI: begin
          s_d.rdata = s_q.op[15:8];
        end
        `FSPS_REG_STAT: begin
          s_d.rdata = {6'h00, s_q.halt, s_q.block};
        end
        `FSPS_REG_LOCK: begin
          s_d.rdata = s_q.lock;
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // ****************************************
    // command sequencer
    // ****************************************
    case (s_q.st)
      FSPS_IDLE: begin
        // nothing runs until a control write arms a command
      end
      FSPS_ARMED: begin
        s_d.win = s_q.win + 3'd1;
        if (cmd == `FSPS_CMD_SIG_READ || cmd == `FSPS_CMD_LOCKSET) begin
          // lock/fuse/signature read via load instruction
          if (load_ok) begin
            s_d.ld_valid = 1'b1;
            if (cmd == `FSPS_CMD_SIG_READ) begin
              s_d.ld_data = fsps_sig_byte(zlow);
            end else begin
              s_d.ld_data = fsps_fuse_byte(zlow, s_q.lock);
            end
            s_d.ctl[5:0] = 6'h00;
            s_d.st = FSPS_IDLE;
          end else if (store_ok && cmd == `FSPS_CMD_LOCKSET) begin
            // lock set: zeros program, locks only go low
            s_d.lock = s_q.lock & {2'b11, s_q.op[5:0]};
            s_d.cnt = 23'(WRITE_CYC);
            s_d.st = FSPS_LOCKING;
          end else if (store_ok || win_last) begin
            // a store after a signature read arm just drops the command
            s_d.ctl[5:0] = 6'h00;
            s_d.st = FSPS_IDLE;
          end
        end else if (store_ok) begin
          case (cmd)
            `FSPS_CMD_LOAD: begin
              // a second load to a word is unsupported; last wins
              s_d.buf_data[widx*16 +: 16] = s_q.op;
              s_d.buf_full[widx] = 1'b1;
              s_d.ctl[5:0] = 6'h00;
              s_d.st = FSPS_IDLE;
            end
            `FSPS_CMD_WRITE: begin
              s_d.page = s_q.z[16:8];
              s_d.cnt = 23'(WRITE_CYC);
              s_d.block = 1'b1;
              s_d.halt = (s_q.z[16:8] >= `FSPS_NOREAD_PAGE);
              s_d.st = FSPS_WRITING;
            end
            `FSPS_CMD_REEN: begin
              s_d.block = 1'b0;
              s_d.buf_full = '0;
              s_d.buf_data = '0;
              s_d.ctl[5:0] = 6'h00;
              s_d.st = FSPS_IDLE;
            end
            default: begin
              s_d.ctl[5:0] = 6'h00;
              s_d.st = FSPS_IDLE;
            end
          endcase
        end else if (win_last) begin
          s_d.ctl[5:0] = 6'h00;
          s_d.st = FSPS_IDLE;
        end
      end
      FSPS_WRITING, FSPS_LOCKING: begin
        // enable held until the operation ends
        s_d.cnt = s_q.cnt - 23'd1;
        if (s_q.cnt <= 23'd1) begin
          if (s_q.st == FSPS_WRITING) begin
            s_d.buf_full = '0;
            s_d.buf_data = '0;
          end
          s_d.halt = 1'b0;
          s_d.ctl[5:0] = 6'h00;
          s_d.st = FSPS_IDLE;
        end
      end
      default: begin
        s_d.st = FSPS_IDLE;
      end
    endcase

    // ****************************************
    // status and interrupt
    // ****************************************
    // eeprom activity never touches the buffer contents
    s_d.ctl[`FSPS_CTL_BUSY] = s_d.block;
    // level request, not a pulse: software must clear the enable to stop it
    s_d.irq = s_d.ctl[`FSPS_CTL_IE] & ~s_d.ctl[`FSPS_CTL_STORE_EN];
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.st <= FSPS_IDLE;
      s_q.lock <= `FSPS_LOCK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = s_q.rdata;
  assign load_data = s_q.ld_data;
  assign load_data_valid = s_q.ld_valid;
  assign cpu_halt = s_q.halt;
  assign rww_read_block = s_q.block;
  assign store_irq = s_q.irq;

endmodule

// >>> sim/fsps_cpu_model.sv
`timescale 1ns/1ns
// ********
// cpu side
// ********
module fsps_cpu_model (
  input wire logic clock,
  input wire logic do_store,
  input wire logic do_load,
  output logic store_instr,
  output logic load_instr
);
  // one-cycle pulses; the bench times them against the windows
  always_ff @(posedge clock) begin
    store_instr <= do_store;
    load_instr <= do_load;
  end
endmodule

// >>> sim/fsps_sequencer_assertions.sv
`timescale 1ns/1ns
// ********
// checker
// ********
module fsps_sequencer_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic store_instr,
  input wire logic load_instr,
  input wire logic eeprom_write_active_bit,
  input wire logic load_data_valid,
  input wire logic cpu_halt,
  input wire logic rww_read_block,
  input wire logic store_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_vld; load_data_valid |-> $past(load_instr); endproperty
  property p_eep; eeprom_write_active_bit && load_instr |=> !load_data_valid;
  endproperty
  property p_once; load_data_valid |=> !load_data_valid; endproperty
  property p_up;
    $rose(rww_read_block) |-> $past(store_instr)
      && !$past(eeprom_write_active_bit);
  endproperty
  property p_dn; $fell(rww_read_block) |-> $past(store_instr); endproperty
  property p_hb; cpu_halt |-> rww_read_block; endproperty
  property p_len; $rose(cpu_halt) |-> cpu_halt[*4] ##[1:12] !cpu_halt;
  endproperty
  property p_irq; cpu_halt |-> !store_irq; endproperty
  a_vld: assert property (p_vld) else $error("stray load data");
  a_eep: assert property (p_eep) else $error("load served");
  a_once: assert property (p_once) else $error("valid too long");
  a_up: assert property (p_up) else $error("block rose alone");
  a_dn: assert property (p_dn) else $error("block fell alone");
  a_hb: assert property (p_hb) else $error("halt without block");
  a_len: assert property (p_len) else $error("halt length");
  a_irq: assert property (p_irq) else $error("irq while busy");
  c_vld: cover property (load_data_valid);
  c_halt: cover property ($rose(cpu_halt));
  c_reen: cover property ($fell(rww_read_block));
endmodule
bind fsps_sequencer fsps_sequencer_checker i_chk (.clock(clock),
  .sys_rst(sys_rst), .store_instr(store_instr), .load_instr(load_instr),
  .eeprom_write_active_bit(eeprom_write_active_bit),
  .load_data_valid(load_data_valid), .cpu_halt(cpu_halt),
  .rww_read_block(rww_read_block), .store_irq(store_irq));

// >>> sim/testbench.sv
`timescale 1ns/1ns
`include "fsps_params.svh"
// ********
// bench
// ********
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic eeprom_write_active_bit = 1'b0;
  logic do_store = 1'b0;
  logic do_load = 1'b0;
  logic store_instr, load_instr, load_data_valid;
  logic cpu_halt, rww_read_block, store_irq;
  logic [7:0] reg_rdata, load_data;
  int num_errors = 0;
  int check_count = 0;
  always #2 clock = ~clock;
  fsps_cpu_model i_cpu (.clock(clock), .do_store(do_store),
    .do_load(do_load), .store_instr(store_instr), .load_instr(load_instr));
  // short write time keeps the run brief
  fsps_sequencer #(.WRITE_CYC(8)) i_dut (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_instr(store_instr),
    .load_instr(load_instr),
    .eeprom_write_active_bit(eeprom_write_active_bit),
    .load_data(load_data), .load_data_valid(load_data_valid),
    .cpu_halt(cpu_halt), .rww_read_block(rww_read_block),
    .store_irq(store_irq));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(n, e, reg_rdata);
  endtask
  task setz(input logic [16:0] z);
    wr(`FSPS_REG_ZLO, z[7:0]);
    wr(`FSPS_REG_ZHI, z[15:8]);
    wr(`FSPS_REG_ZEXT, {7'h00, z[16]});
  endtask
  // control write, then a store or load dly cycles later
  task cmd(input logic [7:0] c, input int dly, input logic st);
    wr(`FSPS_REG_CTL, c);
    repeat (dly) @(posedge clock);
    if (st) do_store <= 1'b1;
    else do_load <= 1'b1;
    @(posedge clock);
    do_store <= 1'b0;
    do_load <= 1'b0;
    @(posedge clock);
    @(negedge clock);
  endtask
  task rb(input logic [16:0] z, input logic [7:0] c, e, m);
    setz(z);
    cmd(c, 0, 1'b0);
    chk("valid", 8'h01, {7'h00, load_data_valid});
    chk("load", e & m, load_data & m);
  endtask
  task t_lock;
    rd(`FSPS_REG_LOCK, 8'hff, "lock");
    setz(17'h00001);
    wr(`FSPS_REG_OPLO, 8'hf0);
    cmd(8'h09, 0, 1'b1);
    chk("block", 8'h00, {7'h00, rww_read_block});
    repeat (20) @(posedge clock);
    rd(`FSPS_REG_LOCK, 8'hf0, "lock");
    $display("lock set test done");
  endtask
  task t_read;
    rb(17'h00001, 8'h09, 8'hf0, 8'hff);
    rb(17'h00000, 8'h09, `FSPS_FUSE_LO, 8'hff);
    rb(17'h00003, 8'h09, `FSPS_FUSE_HI, 8'hff);
    rb(17'h00002, 8'h09, `FSPS_FUSE_EXT, 8'h07);
    rb(17'h00000, 8'h21, `FSPS_SIG0, 8'hff);
    rb(17'h00002, 8'h21, `FSPS_SIG1, 8'hff);
    rb(17'h00004, 8'h21, `FSPS_SIG2, 8'hff);
    rb(17'h00001, 8'h21, `FSPS_OSCCAL, 8'hff);
    cmd(8'h09, 3, 1'b0);
    chk("late", 8'h00, {7'h00, load_data_valid});
    rd(`FSPS_REG_CTL, 8'h00, "ctl");
    $display("read test done");
  endtask
  task t_refuse;
    eeprom_write_active_bit <= 1'b1;
    cmd(8'h09, 0, 1'b0);
    chk("valid", 8'h00, {7'h00, load_data_valid});
    cmd(8'h05, 0, 1'b1);
    chk("block", 8'h00, {7'h00, rww_read_block});
    eeprom_write_active_bit <= 1'b0;
    cmd(8'h05, 4, 1'b1);
    chk("block", 8'h00, {7'h00, rww_read_block});
    wr(`FSPS_REG_CTL, 8'h05);
    eeprom_write_active_bit <= 1'b1;
    do_store <= 1'b1;
    @(posedge clock);
    do_store <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk("block", 8'h00, {7'h00, rww_read_block});
    eeprom_write_active_bit <= 1'b0;
    $display("refuse test done");
  endtask
  task t_write;
    setz(17'h00002);
    wr(`FSPS_REG_OPLO, 8'h34);
    cmd(8'h01, 0, 1'b1);
    setz({9'd480, 8'h00});
    cmd(8'h85, 0, 1'b1);
    chk("halt", 8'h01, {7'h00, cpu_halt});
    rd(`FSPS_REG_STAT, 8'h03, "stat");
    chk("block", 8'h01, {7'h00, rww_read_block});
    for (int i = 0; i < 40 && cpu_halt; i++) @(posedge clock);
    @(negedge clock);
    chk("block", 8'h01, {7'h00, rww_read_block});
    chk("irq", 8'h01, {7'h00, store_irq});
    cmd(8'h11, 0, 1'b1);
    chk("block", 8'h00, {7'h00, rww_read_block});
    setz(17'h00000);
    cmd(8'h05, 0, 1'b1);
    chk("halt", 8'h00, {7'h00, cpu_halt});
    chk("block", 8'h01, {7'h00, rww_read_block});
    repeat (20) @(posedge clock);
    cmd(8'h11, 0, 1'b1);
    chk("block", 8'h00, {7'h00, rww_read_block});
    $display("write test done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_lock;
    t_read;
    t_refuse;
    t_write;
    complete_run;
  end
  // the tests need well under 2000 cycles
  initial begin
    repeat (4000) @(posedge clock);
    num_errors++;
    complete_run;
  end
endmodule
